// >>> design/clock_multiplier_control.sv
`timescale 1ns/1ps
`include "clock_mult_cfg.svh"

// How it works
// - multiplier runs only while enable is set
// - init write while enabled starts lock
// - select picks source and times two/four
// - crystal mode claims both oscillator pins
// - rc, cap, cmos claim output pin only
// - output two or four times input, scaled by code except internal x2
module clock_multiplier_control
    import clock_mult_pkg::*;
#(
    parameter int LOCK_QUAL_CYCLES = `CMC_LOCK_QUAL_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_wr_data,
    output logic [7:0] sfr_rd_data,
    // external oscillator status
    input clock_mult_pkg::ext_osc_mode_t ext_osc_mode,
    // analog multiplier side
    input wire logic pll_lock_raw,
    output logic mult_run,
    output logic mult_init_start,
    output logic mult_src_ext,
    output logic mult_times4,
    output logic [2:0] mult_scale,
    // system clock selection
    output logic mult_clk_ok,
    // port pin takeover
    output logic osc_pin_in_claim,
    output logic osc_pin_out_claim
);
    import clock_mult_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_n;
    logic rst_sync_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // scale code actually applied for a given select
    function automatic logic [2:0] eff_scale(input logic [1:0] sel, input logic [2:0] code);
        eff_scale = (sel == SEL_INT_X2) ? `CMC_SCALE_NONE : code;
    endfunction

    // true for crystal or resonator modes
    function automatic logic is_xtal(input ext_osc_mode_t mode);
        is_xtal = (mode == OSC_XTAL) || (mode == OSC_XTAL_DIV2);
    endfunction

    // true whenever the oscillator drive circuit is on
    function automatic logic osc_on(input ext_osc_mode_t mode);
        osc_on = (mode != OSC_OFF0) && (mode != OSC_OFF1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // lock qualification

    logic lock_good;
    logic qual_restart;

    lock_qualifier #(
        .QUAL_CYCLES(LOCK_QUAL_CYCLES)
    ) u_lock_qual (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .restart(qual_restart),
        .lock_raw(pll_lock_raw),
        .lock_good(lock_good)
    );

    ////////////////////////////////////////////////////////////////////////////
    // control register and state

    logic enable;
    logic init_bit;
    logic [2:0] scale_code;
    logic [1:0] sel_code;
    mult_state_t state;
    logic next_enable;
    logic next_init_bit;
    logic [2:0] next_scale_code;
    logic [1:0] next_sel_code;
    mult_state_t next_state;
    logic reg_write;
    logic init_req;

    assign reg_write = sfr_wr_en && (sfr_addr == `CMC_REG_ADDR);
    // init only counts when enable was already set before this write
    assign init_req = reg_write && sfr_wr_data[`CMC_BIT_INIT] && enable
                      && sfr_wr_data[`CMC_BIT_ENABLE];
    assign qual_restart = init_req || (state == ST_OFF);

    // register writes and multiplier sequencing
    always_comb begin
        next_enable = enable;
        next_init_bit = init_bit;
        next_scale_code = scale_code;
        next_sel_code = sel_code;
        next_state = state;
        if (reg_write) begin
            next_enable = sfr_wr_data[`CMC_BIT_ENABLE];
            next_init_bit = sfr_wr_data[`CMC_BIT_INIT];
            next_scale_code = sfr_wr_data[`CMC_SCALE_HI:`CMC_SCALE_LO];
            next_sel_code = sfr_wr_data[`CMC_SEL_HI:`CMC_SEL_LO];
        end
        case (state)
            ST_OFF: begin
                if (next_enable) next_state = ST_ENABLED;
            end
            ST_ENABLED: begin
                if (init_req) next_state = ST_LOCKING;
            end
            ST_LOCKING: begin
                if (lock_good) next_state = ST_LOCKED;
            end
            ST_LOCKED: begin
                // new init or lost lock drops ready
                if (init_req || !lock_good) next_state = ST_LOCKING;
            end
            default: next_state = ST_OFF;
        endcase
        // disable wins over all, clear resets
        if (!next_enable) next_state = ST_OFF;
    end

    // register control state
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            enable <= 1'(`CMC_REG_RESET >> `CMC_BIT_ENABLE);
            init_bit <= 1'b0;
            scale_code <= 3'h0;
            sel_code <= 2'h0;
            state <= ST_OFF;
        end else begin
            enable <= next_enable;
            init_bit <= next_init_bit;
            scale_code <= next_scale_code;
            sel_code <= next_sel_code;
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    logic [7:0] next_rd_data;
    logic next_run;
    logic next_init_start;
    logic next_src_ext;
    logic next_times4;
    logic [2:0] next_scale;
    logic next_clk_ok;
    logic next_pin_in;
    logic next_pin_out;

    // output values, read data from the current registers, multiplier outputs from the next state
    always_comb begin
        next_rd_data = 8'h00;
        if (sfr_addr == `CMC_REG_ADDR) begin
            next_rd_data[`CMC_BIT_ENABLE] = enable;
            next_rd_data[`CMC_BIT_INIT] = init_bit;
            next_rd_data[`CMC_BIT_LOCKED] = (state == ST_LOCKED);
            next_rd_data[`CMC_SCALE_HI:`CMC_SCALE_LO] = scale_code;
            next_rd_data[`CMC_SEL_HI:`CMC_SEL_LO] = sel_code;
        end
        next_run = (next_state != ST_OFF);
        next_init_start = init_req && next_enable;
        next_src_ext = next_sel_code[0];
        next_times4 = next_sel_code[1];
        next_scale = eff_scale(next_sel_code, next_scale_code);
        next_clk_ok = (next_state == ST_LOCKED);
        next_pin_in = is_xtal(ext_osc_mode);
        // any active mode claims output pin
        next_pin_out = osc_on(ext_osc_mode);
    end

    // register every output
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sfr_rd_data <= 8'h00;
            mult_run <= 1'b0;
            mult_init_start <= 1'b0;
            mult_src_ext <= 1'b0;
            mult_times4 <= 1'b0;
            mult_scale <= 3'h0;
            mult_clk_ok <= 1'b0;
            osc_pin_in_claim <= 1'b0;
            osc_pin_out_claim <= 1'b0;
        end else begin
            sfr_rd_data <= next_rd_data;
            mult_run <= next_run;
            mult_init_start <= next_init_start;
            mult_src_ext <= next_src_ext;
            mult_times4 <= next_times4;
            mult_scale <= next_scale;
            mult_clk_ok <= next_clk_ok;
            osc_pin_in_claim <= next_pin_in;
            osc_pin_out_claim <= next_pin_out;
        end
    end

endmodule

// >>> design/clock_mult_cfg.svh
`ifndef CLOCK_MULT_CFG_SVH
`define CLOCK_MULT_CFG_SVH

// control register address on the special function register port
`define CMC_REG_ADDR 8'h97
// control register reset value
`define CMC_REG_RESET 8'h00

// field positions inside the control register
`define CMC_BIT_ENABLE 7
`define CMC_BIT_INIT 6
`define CMC_BIT_LOCKED 5
`define CMC_SCALE_HI 4
`define CMC_SCALE_LO 2
`define CMC_SEL_HI 1
`define CMC_SEL_LO 0

// scale code that means no output scaling
`define CMC_SCALE_NONE 3'h0

// consecutive locked cycles before lock is trusted
`define CMC_LOCK_QUAL_CYCLES 16

`endif

// >>> design/clock_mult_pkg.sv
package clock_mult_pkg;

    // control state, one-hot
    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_ENABLED = 4'b0010,
        ST_LOCKING = 4'b0100,
        ST_LOCKED  = 4'b1000
    } mult_state_t;

    // multiplier input select codes
    typedef enum logic [1:0] {
        SEL_INT_X2 = 2'h0,
        SEL_EXT_X2 = 2'h1,
        SEL_INT_X4 = 2'h2,
        SEL_EXT_X4 = 2'h3
    } mult_sel_t;

    // external oscillator mode codes
    typedef enum logic [2:0] {
        OSC_OFF0      = 3'h0,
        OSC_OFF1      = 3'h1,
        OSC_CMOS      = 3'h2,
        OSC_CMOS_DIV2 = 3'h3,
        OSC_RC        = 3'h4,
        OSC_CAP       = 3'h5,
        OSC_XTAL      = 3'h6,
        OSC_XTAL_DIV2 = 3'h7
    } ext_osc_mode_t;

endpackage

// >>> design/lock_qualifier.sv
`timescale 1ns/1ps
`include "clock_mult_cfg.svh"

module lock_qualifier #(
    parameter int QUAL_CYCLES = `CMC_LOCK_QUAL_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    // control
    input wire logic restart,
    input wire logic lock_raw,
    // result
    output logic lock_good
);

    localparam int CW = $clog2(QUAL_CYCLES + 1);
    localparam logic [CW-1:0] CNT_TOP = CW'(QUAL_CYCLES);

    // refuse counts the counter cannot hold
    if (QUAL_CYCLES < 1 || QUAL_CYCLES > 65535) begin : g_bad_count
        $error("lock_qualifier: QUAL_CYCLES out of range");
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_lock_good;

    // count consecutive locked cycles, restart on a new init
    always_comb begin
        next_count = count;
        next_lock_good = lock_good;
        if (restart || !lock_raw) begin
            next_count = '0;
            next_lock_good = 1'b0;
        end else if (count != CNT_TOP) begin
            next_count = count + CW'(1);
        end else begin
            next_lock_good = 1'b1;
        end
    end

    // register counter and result
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count <= '0;
            lock_good <= 1'b0;
        end else begin
            count <= next_count;
            lock_good <= next_lock_good;
        end
    end

endmodule

// >>> test/clock_mult_monitor.sv
`timescale 1ns/1ps
module clock_mult_monitor
    import clock_mult_pkg::*;
#(
    parameter int LOCK_QUAL_CYCLES = 16
) (
    // clock, reset, register port
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_wr_data,
    input wire logic [7:0] sfr_rd_data,
    input clock_mult_pkg::ext_osc_mode_t ext_osc_mode,
    // multiplier side and pins
    input wire logic pll_lock_raw,
    input wire logic mult_run,
    input wire logic mult_init_start,
    input wire logic mult_src_ext,
    input wire logic mult_times4,
    input wire logic [2:0] mult_scale,
    input wire logic mult_clk_ok,
    input wire logic osc_pin_in_claim,
    input wire logic osc_pin_out_claim
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic wr_hit;
    int raw_run;
    // write to the control register
    assign wr_hit = sfr_wr_en && sfr_addr == 8'h97;
    // consecutive cycles of raw lock seen so far
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw_run <= 0;
        end else begin
            raw_run <= pll_lock_raw ? raw_run + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_run_follows_en: assert property (
        wr_hit |=> mult_run == $past(sfr_wr_data[7])) else $error("run differs from enable");
    a_init_on_write: assert property (
        wr_hit |=> mult_init_start == ($past(sfr_wr_data[7:6]) == 2'b11 && $past(mult_run)))
        else $error("init pulse wrong for write");
    a_init_one_pulse: assert property (
        mult_init_start |-> $past(wr_hit && sfr_wr_data[7:6] == 2'b11))
        else $error("stray init pulse");
    a_ok_needs_raw: assert property (
        !pll_lock_raw [*3] |-> !mult_clk_ok) else $error("clock ok without lock");
    a_ok_needs_run: assert property (
        mult_clk_ok |-> $past(mult_run)) else $error("clock ok while off");
    a_init_drops_ok: assert property (
        mult_init_start |=> !mult_clk_ok) else $error("clock ok kept over init");
    a_scale_bypass: assert property (
        !mult_src_ext && !mult_times4 |-> mult_scale == 3'h0) else $error("scale not ignored");
    a_select_map: assert property (
        wr_hit |=> {mult_times4, mult_src_ext} == $past(sfr_wr_data[1:0]))
        else $error("select decode wrong");
    a_pin_claims: assert property (
        {osc_pin_in_claim, osc_pin_out_claim} ==
        {$past(ext_osc_mode[2:1]) == 2'b11, $past(ext_osc_mode) > 3'h1})
        else $error("pin claim wrong");
    a_lock_qualified: assert property (
        $rose(mult_clk_ok) |-> raw_run > LOCK_QUAL_CYCLES)
        else $error("clock ok before lock settled");
endmodule

// >>> test/pll_model.sv
`timescale 1ns/1ps
module pll_model #(
    parameter int FAST = 3,
    parameter int SLOW = 20
) (
    // multiplier control in
    input wire logic clk_sys,
    input wire logic run,
    input wire logic init,
    input wire logic lose,
    input wire logic slow,
    // raw lock out
    output logic lock_raw
);
    logic busy = 1'b0;
    int cnt = 0;
    initial lock_raw = 1'b0;
    // locks only after init while running
    always @(posedge clk_sys) begin
        if (!run || lose || init) begin
            busy <= init && run && !lose;
            cnt <= 0;
            lock_raw <= 1'b0;
        end else if (busy && cnt >= (slow ? SLOW : FAST)) begin
            lock_raw <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clock_mult_pkg::*;
    logic clk_sys, rst_n, sfr_wr_en, lose, slow, pll_lock_raw, mult_run, mult_init_start;
    logic mult_src_ext, mult_times4, mult_clk_ok, osc_pin_in_claim, osc_pin_out_claim;
    logic [7:0] sfr_addr, sfr_wr_data, sfr_rd_data, cfg, d;
    logic [2:0] mult_scale;
    ext_osc_mode_t ext_osc_mode;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    clock_multiplier_control #(.LOCK_QUAL_CYCLES(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data),
        .sfr_rd_data(sfr_rd_data), .ext_osc_mode(ext_osc_mode), .pll_lock_raw(pll_lock_raw),
        .mult_run(mult_run), .mult_init_start(mult_init_start), .mult_src_ext(mult_src_ext),
        .mult_times4(mult_times4), .mult_scale(mult_scale), .mult_clk_ok(mult_clk_ok),
        .osc_pin_in_claim(osc_pin_in_claim), .osc_pin_out_claim(osc_pin_out_claim));
    pll_model i_pll (.clk_sys(clk_sys), .run(mult_run), .init(mult_init_start), .lose(lose),
        .slow(slow), .lock_raw(pll_lock_raw));
    // clock and timeout
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wr_data <= v;
        sfr_wr_en <= 1'b1;
        @(posedge clk_sys);
        sfr_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        sfr_addr <= a;
        @(posedge clk_sys);
        #1 d = sfr_rd_data;
    endtask
    task automatic wait_ok(input logic want);
        for (int i = 0; i < 40 && mult_clk_ok !== want; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check("clk_ok", {7'h0, mult_clk_ok}, {7'h0, want});
    endtask
    function automatic logic [7:0] exp_scale(input logic [7:0] c);
        return (c[1:0] == 2'h0) ? 8'h00 : {5'h0, c[4:2]};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sfr_wr_en, lose, slow, sfr_addr, sfr_wr_data} = '0;
        ext_osc_mode = OSC_OFF0;
        void'($urandom(71442));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(8'h97);
        check("reset value", d, 8'h00);
        rd(8'h55);
        check("unmapped read", d, 8'h00);
        $display("test reset done");
        // clear first, then select and scale, enable, wait, init, poll
        wr(8'h97, 8'h00);
        // every select code, scale ignored only for internal doubled
        for (int s = 0; s < 4; s++) begin
            cfg = {3'h0, 3'($urandom()), 2'(s)};
            if (s == 0) cfg[4:2] = 3'h7;
            wr(8'h97, cfg);
            check("src_ext", {7'h0, mult_src_ext}, {7'h0, cfg[0]});
            check("times4", {7'h0, mult_times4}, {7'h0, cfg[1]});
            check("scale", {5'h0, mult_scale}, exp_scale(cfg));
            rd(8'h97);
            check("readback", d, cfg);
        end
        $display("test select done");
        // external crystal chosen and settled long before init
        @(posedge clk_sys);
        ext_osc_mode <= OSC_XTAL;
        wr(8'h97, 8'h80 | cfg);
        check("run", {7'h0, mult_run}, 8'h01);
        // over 5 us at 8 ns per cycle before init
        repeat (640) @(posedge clk_sys);
        #1;
        check("clk_ok early", {7'h0, mult_clk_ok}, 8'h00);
        wr(8'h97, 8'hC0 | cfg);
        check("init pulse", {7'h0, mult_init_start}, 8'h01);
        wait_ok(1'b1);
        rd(8'h97);
        check("locked bit", d, 8'hE0 | cfg);
        // re-init while locked, slow answer
        slow <= 1'b1;
        wr(8'h97, 8'hC0 | cfg);
        rd(8'h97);
        check("relock bit", d, 8'hC0 | cfg);
        wait_ok(1'b1);
        @(posedge clk_sys);
        lose <= 1'b1;
        wait_ok(1'b0);
        @(posedge clk_sys);
        lose <= 1'b0;
        $display("test lock done");
        wr(8'h97, 8'h00);
        check("run off", {7'h0, mult_run}, 8'h00);
        rd(8'h97);
        check("cleared", d, 8'h00);
        wr(8'h97, 8'h40);
        check("init refused", {7'h0, mult_init_start}, 8'h00);
        // init in the same write that enables starts nothing
        wr(8'h97, 8'hC0);
        check("init needs prior enable", {7'h0, mult_init_start}, 8'h00);
        check("run on late enable", {7'h0, mult_run}, 8'h01);
        $display("test disable done");
        // claims name the pins software skips and sets as inputs
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            ext_osc_mode <= ext_osc_mode_t'(m);
            @(posedge clk_sys);
            #1;
            check("pin in", {7'h0, osc_pin_in_claim}, {7'h0, m >= 6});
            check("pin out", {7'h0, osc_pin_out_claim}, {7'h0, m >= 2});
        end
        $display("test pins done");
        results();
    end
endmodule
bind clock_multiplier_control clock_mult_monitor #(.LOCK_QUAL_CYCLES(LOCK_QUAL_CYCLES)) i_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wr_data(sfr_wr_data), .sfr_rd_data(sfr_rd_data), .ext_osc_mode(ext_osc_mode),
    .pll_lock_raw(pll_lock_raw), .mult_run(mult_run), .mult_init_start(mult_init_start),
    .mult_src_ext(mult_src_ext), .mult_times4(mult_times4), .mult_scale(mult_scale),
    .mult_clk_ok(mult_clk_ok), .osc_pin_in_claim(osc_pin_in_claim),
    .osc_pin_out_claim(osc_pin_out_claim));
